/* File: src/mmu_reg_regs.vh */
// Register map constants for the translation unit register front end.
// Assumes a 17-bit byte offset inside the two-page register window.
`ifndef MMU_REG_REGS_VH
`define MMU_REG_REGS_VH

// Page layout
`define PAGE_SIZE 17'h10000
`define SPAN_TOP 17'h1FFFF
`define SEC_LO 17'h08000
`define SEC_HI 17'h0BFFF

// Page 0 read-only registers
`define OFF_FEATURE_ID_0 17'h00000
`define OFF_FEATURE_ID_1 17'h00004
`define OFF_FEATURE_ID_2 17'h00008
`define OFF_FEATURE_ID_3 17'h0000C
`define OFF_FEATURE_ID_4 17'h00010
`define OFF_FEATURE_ID_5 17'h00014
`define OFF_IMPLEMENTER_IDENT 17'h00018
`define OFF_ARCHITECTURE_IDENT 17'h0001C
`define OFF_CONTROL_0_ACK 17'h00024
`define OFF_UNIT_STATUS 17'h00040
`define OFF_IRQ_CONTROL_ACK 17'h00054
`define OFF_GLOBAL_ERROR_FLAGS 17'h00060
`define OFF_TRANSLATE_RESULT 17'h00118

// Page 0 read/write registers, except the read-only OFF_TRANSLATE_RESULT_HI
`define OFF_CONTROL_0 17'h00020
`define OFF_CONTROL_1 17'h00028
`define OFF_CONTROL_2 17'h0002C
`define OFF_GLOBAL_BYPASS 17'h00044
`define OFF_ALT_GLOBAL_BYPASS 17'h00048
`define OFF_IRQ_CONTROL 17'h00050
`define OFF_GLOBAL_ERROR_ACK 17'h00064
`define OFF_CMDQ_BASE 17'h00090
`define OFF_TRANSLATE_CONTROL 17'h00100
`define OFF_GLOBAL_ERROR_IRQ_ADDR 17'h00068
`define OFF_GLOBAL_ERROR_IRQ_ADDR_HI 17'h0006C
`define OFF_GLOBAL_ERROR_IRQ_DATA 17'h00070
`define OFF_GLOBAL_ERROR_IRQ_ATTR 17'h00074
`define OFF_STREAM_TABLE_BASE 17'h00080
`define OFF_STREAM_TABLE_BASE_HI 17'h00084
`define OFF_STREAM_TABLE_CONFIG 17'h00088
`define OFF_CMDQ_BASE_HI 17'h00094
`define OFF_CMDQ_PRODUCER 17'h00098
`define OFF_CMDQ_CONSUMER 17'h0009C
`define OFF_EVENTQ_BASE 17'h000A0
`define OFF_EVENTQ_BASE_HI 17'h000A4
`define OFF_EVENTQ_IRQ_ADDR 17'h000B0
`define OFF_EVENTQ_IRQ_ADDR_HI 17'h000B4
`define OFF_EVENTQ_IRQ_DATA 17'h000B8
`define OFF_EVENTQ_IRQ_ATTR 17'h000BC
`define OFF_PRIQ_BASE 17'h000C0
`define OFF_PRIQ_BASE_HI 17'h000C4
`define OFF_PRIQ_IRQ_ADDR 17'h000D0
`define OFF_PRIQ_IRQ_ADDR_HI 17'h000D4
`define OFF_PRIQ_IRQ_DATA 17'h000D8
`define OFF_PRIQ_IRQ_ATTR 17'h000DC
`define OFF_TRANSLATE_STREAM 17'h00108
`define OFF_TRANSLATE_STREAM_HI 17'h0010C
`define OFF_TRANSLATE_INPUT 17'h00110
`define OFF_TRANSLATE_INPUT_HI 17'h00114
`define OFF_TRANSLATE_RESULT_HI 17'h0011C

// Page 1 queue index registers
`define OFF_EVENTQ_PRODUCER 17'h100A8
`define OFF_EVENTQ_CONSUMER 17'h100AC
`define OFF_PRIQ_PRODUCER 17'h100C8
`define OFF_PRIQ_CONSUMER 17'h100CC

// Secure registers
`define OFF_SECURE_FEATURE_ID_1 17'h08004
`define OFF_SECURE_INIT_CONTROL 17'h0803C

// Field positions
`define CR0_CMDQ_EN_BIT 3
`define SECURE_ID_1_IMPLEMENTED_BIT 31

// Reset and constant read values
`define RESET_WORD 32'h00000000
`define FEATURE_ID_VALUE 32'h00000000
`define IDENT_VALUE 32'h00000001
`define STATUS_VALUE 32'h00000000
`define NO_SLOT 6'h3F
`define NUM_SLOTS 40

`endif

/* File: src/mmu_register_access_decoder.v */
// APB register front end for the translation unit programming interface.
// Assumes a 32-bit APB4 master; the upper address bits are decoded outside.
//
// Function
// - Registers span two 64KB pages, page 1 at 0x10000
// - Registers are 32-bit little-endian read/write by default
// - Undefined locations outside page 1 are RAZ/WI
// - Page 1 undefined locations use one fixed behaviour
// - Page 0 queue index offsets alias or RAZ/WI
// - Secure registers RAZ/WI to non-secure or unimplemented
// - Reserved bits read zero, software writes zero; the block stores and returns reserved bits as written
// - Aligned 32-bit accesses to all words accepted
// - Aligned 64-bit accesses to 64-bit registers accepted; the 32-bit bus carries only 32-bit halves
// - Illegal size or alignment has defined handling
// - Non-secure access never modifies secure registers
// - 64-bit access over two registers has defined handling
// - Avoid aborting lower-privilege register accesses
// - Aligned 32-bit accesses are single-copy atomic
// - 64-bit fields are two separately writable halves
// - No exclusive or atomic update support needed
// - Writes to read-only registers are ignored
// - Event and PRI queue index registers live in page 1; command queue indexes are in page 0
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "mmu_reg_regs.vh"

module mmu_register_access_decoder #(
  parameter SECURE_STATE_IMPLEMENTED = 1,
  parameter [31:0] IMPLEMENTER_ID = 32'h00000A5A // arbitrary value
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  input wire [2:0] i_pprot,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  // Unit state in
  input wire [31:0] i_global_error_flags,
  // Configuration out
  output wire [31:0] o_control_0,
  output wire [63:0] o_command_queue_base,
  output wire [31:0] o_command_queue_producer,
  output wire [31:0] o_secure_init_control
);

  reg [31:0] store_r [0:`NUM_SLOTS-1];
  reg [31:0] control_0_ack_r;
  reg [31:0] irq_control_ack_r;
  reg [31:0] rd_nxt;
  reg err_nxt;
  reg wr_ok;
  wire [16:0] offset;
  wire [5:0] slot;
  wire setup_phase;
  wire access_phase;
  wire nonsecure;
  wire secure_region;
  wire secure_blocked;
  wire illegal;
  integer k;

  // Map a byte offset onto a storage slot, or NO_SLOT
  function [5:0] slot_of;
    input [16:0] a;
    begin
      case (a)
        `OFF_CONTROL_0: slot_of = 6'h00;
        `OFF_CONTROL_1: slot_of = 6'h01;
        `OFF_CONTROL_2: slot_of = 6'h02;
        `OFF_GLOBAL_BYPASS: slot_of = 6'h03;
        `OFF_ALT_GLOBAL_BYPASS: slot_of = 6'h04;
        `OFF_IRQ_CONTROL: slot_of = 6'h05;
        `OFF_GLOBAL_ERROR_ACK: slot_of = 6'h06;
        `OFF_GLOBAL_ERROR_IRQ_ADDR: slot_of = 6'h07;
        `OFF_GLOBAL_ERROR_IRQ_ADDR_HI: slot_of = 6'h08;
        `OFF_GLOBAL_ERROR_IRQ_DATA: slot_of = 6'h09;
        `OFF_GLOBAL_ERROR_IRQ_ATTR: slot_of = 6'h0A;
        `OFF_STREAM_TABLE_BASE: slot_of = 6'h0B;
        `OFF_STREAM_TABLE_BASE_HI: slot_of = 6'h0C;
        `OFF_STREAM_TABLE_CONFIG: slot_of = 6'h0D;
        `OFF_CMDQ_BASE: slot_of = 6'h0E;
        `OFF_CMDQ_BASE_HI: slot_of = 6'h0F;
        `OFF_CMDQ_PRODUCER: slot_of = 6'h10;
        `OFF_CMDQ_CONSUMER: slot_of = 6'h11;
        `OFF_EVENTQ_BASE: slot_of = 6'h12;
        `OFF_EVENTQ_BASE_HI: slot_of = 6'h13;
        `OFF_EVENTQ_IRQ_ADDR: slot_of = 6'h14;
        `OFF_EVENTQ_IRQ_ADDR_HI: slot_of = 6'h15;
        `OFF_EVENTQ_IRQ_DATA: slot_of = 6'h16;
        `OFF_EVENTQ_IRQ_ATTR: slot_of = 6'h17;
        `OFF_PRIQ_BASE: slot_of = 6'h18;
        `OFF_PRIQ_BASE_HI: slot_of = 6'h19;
        `OFF_PRIQ_IRQ_ADDR: slot_of = 6'h1A;
        `OFF_PRIQ_IRQ_ADDR_HI: slot_of = 6'h1B;
        `OFF_PRIQ_IRQ_DATA: slot_of = 6'h1C;
        `OFF_PRIQ_IRQ_ATTR: slot_of = 6'h1D;
        `OFF_TRANSLATE_CONTROL: slot_of = 6'h1E;
        `OFF_TRANSLATE_STREAM: slot_of = 6'h1F;
        `OFF_TRANSLATE_STREAM_HI: slot_of = 6'h20;
        `OFF_TRANSLATE_INPUT: slot_of = 6'h21;
        `OFF_TRANSLATE_INPUT_HI: slot_of = 6'h22;
        `OFF_EVENTQ_PRODUCER: slot_of = 6'h23;
        `OFF_EVENTQ_CONSUMER: slot_of = 6'h24;
        `OFF_PRIQ_PRODUCER: slot_of = 6'h25;
        `OFF_PRIQ_CONSUMER: slot_of = 6'h26;
        `OFF_SECURE_INIT_CONTROL: slot_of = 6'h27;
        // Page 0 twins of the queue indexes, and every other hole, fall here
        default: slot_of = `NO_SLOT;
      endcase
    end
  endfunction

  assign offset = i_paddr[16:0];
  assign slot = slot_of(offset);
  assign setup_phase = i_psel & ~i_penable;
  assign access_phase = i_psel & i_penable;
  assign o_pready = access_phase;
  assign nonsecure = i_pprot[1];
  assign secure_region = (offset >= `SEC_LO) && (offset <= `SEC_HI);
  assign secure_blocked = secure_region &&
    ((SECURE_STATE_IMPLEMENTED == 0) || nonsecure);

  // Only aligned words are legal on this bus, and writes must enable all four lanes;
  // a 32-bit bus cannot carry a 64-bit access, so halves are the only path
  assign illegal = (i_paddr[1:0] != 2'h0) ||
    (i_pwrite && (i_pstrb != 4'hF));

  // Read value for the addressed word, taken in the setup phase
  always @* begin
    rd_nxt = `RESET_WORD;
    err_nxt = 1'b0;
    if (illegal) begin
      err_nxt = 1'b1;
    end else if (secure_blocked || (offset > `SPAN_TOP)) begin
      // Legal accesses to blocked words answer quietly so lower-privilege software does not abort on them
      rd_nxt = `RESET_WORD;
    end else begin
      case (offset)
        `OFF_FEATURE_ID_0: rd_nxt = `FEATURE_ID_VALUE;
        `OFF_FEATURE_ID_1: rd_nxt = `FEATURE_ID_VALUE;
        `OFF_FEATURE_ID_2: rd_nxt = `FEATURE_ID_VALUE;
        `OFF_FEATURE_ID_3: rd_nxt = `FEATURE_ID_VALUE;
        `OFF_FEATURE_ID_4: rd_nxt = `FEATURE_ID_VALUE;
        `OFF_FEATURE_ID_5: rd_nxt = `FEATURE_ID_VALUE;
        `OFF_IMPLEMENTER_IDENT: rd_nxt = IMPLEMENTER_ID;
        `OFF_ARCHITECTURE_IDENT: rd_nxt = `IDENT_VALUE;
        `OFF_CONTROL_0_ACK: rd_nxt = control_0_ack_r;
        `OFF_UNIT_STATUS: rd_nxt = `STATUS_VALUE;
        `OFF_IRQ_CONTROL_ACK: rd_nxt = irq_control_ack_r;
        `OFF_GLOBAL_ERROR_FLAGS: rd_nxt = i_global_error_flags;
        `OFF_TRANSLATE_RESULT: rd_nxt = `RESET_WORD;
        `OFF_TRANSLATE_RESULT_HI: rd_nxt = `RESET_WORD;
        `OFF_SECURE_FEATURE_ID_1: begin
          rd_nxt = `RESET_WORD;
          rd_nxt[`SECURE_ID_1_IMPLEMENTED_BIT] = (SECURE_STATE_IMPLEMENTED != 0);
        end
        default: begin
          if (slot != `NO_SLOT)
            rd_nxt = store_r[slot];
          else
            rd_nxt = `RESET_WORD;
        end
      endcase
    end
  end

  // Write qualification: read-only, secure and guarded words stay put
  always @* begin
    wr_ok = access_phase && i_pwrite && !illegal && !secure_blocked &&
      (offset <= `SPAN_TOP) && (slot != `NO_SLOT);
    if ((slot == 6'h0E) || (slot == 6'h0F))
      wr_ok = wr_ok && !store_r[0][`CR0_CMDQ_EN_BIT];
  end

  // Storage: each word, including each half of a 64-bit field, on its own.
  // Plain word writes only; no exclusive or read-modify-write support.
  // Reserved bits are kept as written; software is expected to write zero.
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (k = 0; k < `NUM_SLOTS; k = k + 1) begin
        store_r[k] <= `RESET_WORD;
      end
    end else if (wr_ok) begin
      store_r[slot] <= i_pwdata;
    end
  end

  // Acknowledge mirrors follow their control words one cycle later
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control_0_ack_r <= `RESET_WORD;
      irq_control_ack_r <= `RESET_WORD;
    end else begin
      control_0_ack_r <= store_r[0];
      irq_control_ack_r <= store_r[5];
    end
  end

  // Read data and error are registered in the setup phase
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= `RESET_WORD;
      o_pslverr <= 1'b0;
    end else if (setup_phase) begin
      o_prdata <= i_pwrite ? `RESET_WORD : rd_nxt;
      o_pslverr <= err_nxt;
    end
  end

  assign o_control_0 = store_r[0];
  assign o_command_queue_base = {store_r[15], store_r[14]};
  assign o_command_queue_producer = store_r[16];
  assign o_secure_init_control = store_r[39];

endmodule // mmu_register_access_decoder

/* File: tb/mmu_reg_checker_asserts.sv */
// Bus checks for the register front end.
// Bound into the block; sees its ports only.
`timescale 1ns/1ps
module mmu_reg_checker (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  // Bus and state
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  input wire [2:0] i_pprot,
  input wire o_pready,
  input wire o_pslverr,
  input wire [31:0] o_control_0,
  input wire [63:0] o_command_queue_base,
  input wire [31:0] o_secure_init_control
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire su = i_psel && !i_penable;
  wire wa = i_psel && i_penable && i_pwrite;
  wire [16:0] off = i_paddr[16:0];
  chk_zero_wait:
    assert property (o_pready == (i_psel && i_penable)) else $error("ready wrong");
  chk_misalign_abort:
    assert property (su && i_paddr[1:0] != 2'h0 |=> o_pslverr) else $error("no abort");
  chk_strobe_abort:
    assert property (su && i_pwrite && i_pstrb != 4'hF |=> o_pslverr) else $error("no abort");
  chk_legal_ok:
    assert property (su && i_paddr[1:0] == 2'h0 && (!i_pwrite || &i_pstrb) |=> !o_pslverr)
    else $error("bad error");
  chk_abort_keeps:
    assert property (wa && o_pslverr |=> $stable(o_control_0)) else $error("abort wrote");
  chk_ns_secure:
    assert property (wa && i_pprot[1] && off[16:14] == 3'h2 |=> $stable(o_secure_init_control))
    else $error("secure wrote");
  chk_ctrl_write:
    assert property (wa && !o_pslverr && off == 17'h00020 |=> o_control_0 == $past(i_pwdata))
    else $error("control lost");
  chk_half_write:
    assert property (wa && off == 17'h00094 |=> $stable(o_command_queue_base[31:0]))
    else $error("low half hit");
endmodule // mmu_reg_checker

bind mmu_register_access_decoder mmu_reg_checker mmu_reg_checker_i (.*);

/* File: tb/apb_host.sv */
// Bus requester model for the register bench.
// Assumes the block shares its rising-edge clock.
`timescale 1ns/1ps
module apb_host (
  // Clock and answer
  input wire i_ref_clk,
  input wire i_pready,
  input wire [31:0] i_prdata,
  input wire i_pslverr,
  // Request
  output reg o_psel = 1'b0,
  output reg o_penable = 1'b0,
  output reg o_pwrite = 1'b0,
  output reg [31:0] o_paddr = 32'h0,
  output reg [31:0] o_pwdata = 32'h0,
  output reg [3:0] o_pstrb = 4'hF,
  output reg [2:0] o_pprot = 3'h2
);
  // Released address and data lines show inverted values so stale data never looks valid
  task automatic xfer(input w, input [31:0] a, d, input [3:0] s, input [2:0] p,
                      output [31:0] rd, output err, ok);
    int n;
    @(posedge i_ref_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    o_pstrb <= s;
    o_pprot <= p;
    @(posedge i_ref_clk);
    o_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 16);
    rd = i_prdata;
    err = i_pslverr;
    ok = i_pready === 1'b1;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule // apb_host

/* File: tb/mmu_register_access_decoder_test.sv */
// Self-checking bench for the register front end.
// Drives the block through the bus requester model.
`timescale 1ns/1ps
module mmu_register_access_decoder_test;
  reg i_ref_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg [31:0] i_global_error_flags = 32'h000000A5;
  wire i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  wire [31:0] i_paddr, i_pwdata, o_prdata, o_control_0;
  wire [31:0] o_command_queue_producer, o_secure_init_control;
  wire [3:0] i_pstrb;
  wire [2:0] i_pprot;
  wire [63:0] o_command_queue_base;
  int error_cnt = 0;
  int n_checks = 0;
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  mmu_register_access_decoder mmu_register_access_decoder_i (.*);
  apb_host apb_host_i (.i_ref_clk, .i_pready(o_pready), .i_prdata(o_prdata),
    .i_pslverr(o_pslverr), .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
    .o_paddr(i_paddr), .o_pwdata(i_pwdata), .o_pstrb(i_pstrb), .o_pprot(i_pprot));
  task automatic check(input [63:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic acc(input w, input [31:0] a, d, input [3:0] s, input [2:0] p,
                     input [31:0] e, input ee);
    logic [31:0] r;
    logic err, ok;
    apb_host_i.xfer(w, a, d, s, p, r, err, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    check(64'(err), 64'(ee));
    if (!w) check(64'(r), 64'(e));
  endtask
  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    acc(0, 32'h20, 0, 4'hF, 2, 0, 0);
    acc(1, 32'h20, 5, 4'hF, 2, 0, 0);
    acc(0, 32'h24, 0, 4'hF, 2, 5, 0);
    acc(1, 32'h60, 0, 4'hF, 2, 0, 0);
    acc(0, 32'h60, 0, 4'hF, 2, 32'hA5, 0);
    acc(1, 32'h94, 32'hAAAA0001, 4'hF, 2, 0, 0);
    acc(1, 32'h90, 32'h10, 4'hF, 2, 0, 0);
    acc(1, 32'h94, 2, 4'hF, 2, 0, 0);
    @(negedge i_ref_clk);
    check(o_command_queue_base, 64'h00000002_00000010);
    acc(1, 32'hA8, 7, 4'hF, 2, 0, 0);
    acc(0, 32'hA8, 0, 4'hF, 2, 0, 0);
    acc(1, 32'h100A8, 7, 4'hF, 2, 0, 0);
    acc(0, 32'h100A8, 0, 4'hF, 2, 7, 0);
    acc(0, 32'h10020, 0, 4'hF, 2, 0, 0);
    acc(0, 32'h30, 0, 4'hF, 2, 0, 0);
    acc(1, 32'h803C, 3, 4'hF, 2, 0, 0);
    acc(0, 32'h803C, 0, 4'hF, 0, 0, 0);
    acc(1, 32'h803C, 3, 4'hF, 0, 0, 0);
    acc(0, 32'h803C, 0, 4'hF, 0, 3, 0);
    acc(0, 32'h803C, 0, 4'hF, 2, 0, 0);
    acc(0, 32'h22, 0, 4'hF, 2, 0, 1);
    acc(1, 32'h20, 32'hFF, 4'h1, 2, 0, 1);
    acc(0, 32'h20, 0, 4'hF, 2, 5, 0);
    acc(1, 32'h98, 3, 4'hF, 2, 0, 0);
    @(negedge i_ref_clk);
    check(64'(o_command_queue_producer), 64'h3);
    acc(1, 32'h20, 8, 4'hF, 2, 0, 0);
    acc(1, 32'h90, 32'h40, 4'hF, 2, 0, 0);
    @(negedge i_ref_clk);
    check(o_command_queue_base, 64'h00000002_00000010);
    end_of_test();
  end
endmodule // mmu_register_access_decoder_test
